// [design/power_state_sequencer.sv]
// power-state sequencer with wishbone register access
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module power_state_sequencer (
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        WAIT_FOR_INTERRUPT_INSTRUCTION,
	input  wire logic [15:0] WAKE_IRQ,
	input  wire logic        SRAM_REQ,
	output logic             SRAM_GRANT,
	output logic      [13:0] SRAM_PWR_EN,
	output logic      [2:0]  STORE_PWR_EN,
	output logic      [11:0] VDOM_SRC,
	output logic      [1:0]  MAIN_LEVEL,
	output logic             MAIN_REG_EN,
	output logic             CPU_CLK_EN,
	output logic             CPU_PWR_EN,
	output logic             PERIPH_RST
);
	// ****************************************************************
	// state
	// ****************************************************************
	pss_pkg::pstate_e state;
	pss_pkg::pstate_e next_state;
	pss_pkg::pstate_e return_state;
	logic [1:0]  req_kind;
	logic [1:0]  req_target;
	logic        req_pending;
	logic [15:0] wake_en;
	logic [13:0] sram_cfg;
	logic [2:0]  store_cfg;
	logic [11:0] vsel;
	logic [1:0]  main_lvl;
	logic [3:0]  prst_cnt;
	logic [15:0] wake_sync;
	logic        wfi_s1, wfi_s2;
	logic        sreq_s1, sreq_s2;
	logic        wb_req;
	logic        wb_wr;
	logic [31:0] rd_data;

	pss_wake_sync u_sync (
		.clk      (SYS_CLK),
		.rst_n    (RST_N),
		.async_in (WAKE_IRQ),
		.sync_out (wake_sync)
	);

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			{wfi_s2, wfi_s1, sreq_s2, sreq_s1} <= 4'h0;
		end else begin
			{wfi_s2, wfi_s1}   <= {wfi_s1, WAIT_FOR_INTERRUPT_INSTRUCTION};
			{sreq_s2, sreq_s1} <= {sreq_s1, SRAM_REQ};
		end
	end

	// ****************************************************************
	// helper functions
	// ****************************************************************
	function automatic logic is_active(input pss_pkg::pstate_e s);
		return s == pss_pkg::full_active_state ||
			s == pss_pkg::medium_active_state ||
			s == pss_pkg::reduced_active_state;
	endfunction
	function automatic logic is_sleep(input pss_pkg::pstate_e s);
		return s == pss_pkg::full_sleep_state ||
			s == pss_pkg::medium_sleep_state ||
			s == pss_pkg::reduced_sleep_state ||
			s == pss_pkg::shutdown_state;
	endfunction
	function automatic logic src_ok(input int d, input logic [1:0] s);
		unique case (d)
			0:       return s != pss_pkg::SRC_OFF;
			1:       return s == pss_pkg::SRC_MAIN;
			5:       return s == pss_pkg::SRC_SCDC;
			default: return s == pss_pkg::SRC_MAIN ||
				s == pss_pkg::SRC_SCDC;
		endcase
	endfunction

	// ****************************************************************
	// wishbone slave
	// ****************************************************************
	assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wb_wr  = wb_req && WB_WE_I && WB_SEL_I[0];
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (WB_ADR_I)
			pss_pkg::STATE_OFF:   rd_data = {22'h0, req_pending,
				req_kind, req_target, 1'b0, state};
			pss_pkg::REQ_OFF:     rd_data = {27'h0, req_pending,
				req_kind, req_target};
			pss_pkg::WAKEEN_OFF:  rd_data = {16'h0, wake_en};
			pss_pkg::SRAMPWR_OFF: rd_data = {18'h0, sram_cfg};
			pss_pkg::VSEL_OFF:    rd_data = {18'h0, main_lvl, vsel};
			pss_pkg::STORE_OFF:   rd_data = {29'h0, store_cfg};
			pss_pkg::INFO_OFF:    rd_data = {pss_pkg::INFO_VALUE,
				pss_pkg::STORE_BYTES[2], pss_pkg::SRAM_KB[13]};
			default:              rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= wb_req;
			WB_DAT_O <= wb_req ? rd_data : 32'h0000_0000;
		end
	end

	// ****************************************************************
	// software configuration
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			sram_cfg  <= pss_pkg::SRAM_RST;
			store_cfg <= pss_pkg::STORE_RST;
		end else if (wb_wr && WB_ADR_I == pss_pkg::SRAMPWR_OFF &&
			is_active(state)) begin
			sram_cfg  <= WB_DAT_I[13:0];
		end else if (wb_wr && WB_ADR_I == pss_pkg::STORE_OFF) begin
			store_cfg <= WB_DAT_I[2:0];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			vsel     <= pss_pkg::VSEL_RST;
			main_lvl <= pss_pkg::MAIN_115;
		end else if (wb_wr && WB_ADR_I == pss_pkg::VSEL_OFF &&
			!req_pending) begin
			for (int d = 0; d < pss_pkg::N_VDOM; d++) begin
				if (src_ok(d, WB_DAT_I[2*d +: 2]))
					vsel[2*d +: 2] <= WB_DAT_I[2*d +: 2];
			end
			if (!WB_DAT_I[13])
				main_lvl <= WB_DAT_I[13:12];
		end
	end
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			wake_en     <= pss_pkg::WAKEEN_RST;
			req_pending <= 1'b0;
			req_kind    <= 2'h0;
			req_target  <= 2'h0;
		end else if (state != next_state ||
			(req_pending && req_kind == 2'h0)) begin
			req_pending <= 1'b0;
		end else if (wb_wr && !req_pending) begin
			if (WB_ADR_I == pss_pkg::WAKEEN_OFF)
				wake_en <= WB_DAT_I[15:0];
			if (WB_ADR_I == pss_pkg::REQ_OFF) begin
				req_kind    <= WB_DAT_I[3:2];
				req_target  <= WB_DAT_I[1:0];
				req_pending <= WB_DAT_I[3:2] != 2'h0 ||
					WB_DAT_I[1:0] != 2'h0;
			end
		end
	end

	// ****************************************************************
	// power state machine
	// ****************************************************************
	always_comb begin
		next_state = state;
		if (is_active(state) && req_pending) begin
			if (req_kind == 2'h0) begin
				unique case (req_target)
					2'h1:    next_state = pss_pkg::medium_active_state;
					2'h2:    next_state = pss_pkg::reduced_active_state;
					2'h3:    next_state = (state ==
						pss_pkg::reduced_active_state) ?
						pss_pkg::cpu_gated_low_state : state;
					default: next_state = pss_pkg::full_active_state;
				endcase
			end else if (req_kind == pss_pkg::REQ_SLEEP) begin
				unique case (state)
					pss_pkg::full_active_state:
						next_state = pss_pkg::full_sleep_state;
					pss_pkg::medium_active_state:
						next_state = pss_pkg::medium_sleep_state;
					default:
						next_state = pss_pkg::reduced_sleep_state;
				endcase
			end else if (wfi_s2) begin
				if (req_kind == pss_pkg::REQ_SHUTDOWN)
					next_state = pss_pkg::shutdown_state;
				else unique case (state)
					pss_pkg::full_active_state:
						next_state = pss_pkg::full_standby_state;
					pss_pkg::medium_active_state:
						next_state = pss_pkg::medium_standby_state;
					default:
						next_state = pss_pkg::reduced_standby_state;
				endcase
			end
		end else if (!is_active(state) &&
			|(wake_sync & wake_en)) begin
			if (state == pss_pkg::shutdown_state)
				next_state = pss_pkg::full_active_state;
			else
				next_state = return_state;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state        <= pss_pkg::full_active_state;
			return_state <= pss_pkg::full_active_state;
		end else begin
			state <= next_state;
			if (is_active(state) && !is_active(next_state))
				return_state <= state;
		end
	end

	// ****************************************************************
	// power outputs
	// ****************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			SRAM_PWR_EN  <= pss_pkg::SRAM_RST;
			STORE_PWR_EN <= pss_pkg::STORE_RST;
			VDOM_SRC     <= pss_pkg::VSEL_RST;
			MAIN_LEVEL   <= pss_pkg::MAIN_115;
			MAIN_REG_EN  <= 1'b1;
			CPU_CLK_EN   <= 1'b1;
			CPU_PWR_EN   <= 1'b1;
			SRAM_GRANT   <= 1'b0;
		end else begin
			SRAM_PWR_EN  <= (next_state == pss_pkg::shutdown_state) ?
				14'h0000 : sram_cfg;
			STORE_PWR_EN <= store_cfg;
			MAIN_REG_EN  <= !is_sleep(next_state);
			for (int d = 0; d < pss_pkg::N_VDOM; d++)
				VDOM_SRC[2*d +: 2] <= (is_sleep(next_state) &&
					vsel[2*d +: 2] == pss_pkg::SRC_MAIN) ?
					pss_pkg::SRC_OFF : vsel[2*d +: 2];
			MAIN_LEVEL   <= (next_state ==
				pss_pkg::medium_active_state) ?
				pss_pkg::MAIN_105 : main_lvl;
			CPU_CLK_EN   <= is_active(next_state);
			CPU_PWR_EN   <= !is_sleep(next_state) &&
				next_state != pss_pkg::cpu_gated_low_state;
			SRAM_GRANT   <= sreq_s2 &&
				state != pss_pkg::shutdown_state;
		end
	end
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			prst_cnt   <= 4'h0;
			PERIPH_RST <= 1'b1;
		end else begin
			if (is_sleep(state) && is_active(next_state))
				prst_cnt <= pss_pkg::PERIPH_RST_CYC;
			else if (prst_cnt != 4'h0)
				prst_cnt <= prst_cnt - 4'h1;
			PERIPH_RST <= (is_sleep(state) && is_active(next_state)) ||
				prst_cnt > 4'h1;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	property p_reset_full;
		@(posedge SYS_CLK) $rose(RST_N) |->
			state == pss_pkg::full_active_state;
	endproperty
	a_reset_full: assert property (p_reset_full)
		else $error("not in full active after reset");
	property p_no_hw_entry;
		@(posedge SYS_CLK) disable iff (!RST_N)
			is_active(state) && !is_active(next_state) |-> req_pending;
	endproperty
	a_no_hw_entry: assert property (p_no_hw_entry)
		else $error("low-power entry without request");
	property p_wake_enabled;
		@(posedge SYS_CLK) disable iff (!RST_N)
			!is_active(state) && state != pss_pkg::cpu_gated_low_state
			##1 is_active(state) |-> |$past(wake_sync & wake_en);
	endproperty
	a_wake_enabled: assert property (p_wake_enabled)
		else $error("wakeup without enabled source");
	property p_return_same;
		@(posedge SYS_CLK) disable iff (!RST_N)
			state == pss_pkg::medium_standby_state ##1
			is_active(state) |-> state == pss_pkg::medium_active_state;
	endproperty
	a_return_same: assert property (p_return_same)
		else $error("wrong return state");
	property p_shutdown_sram;
		@(posedge SYS_CLK) disable iff (!RST_N)
			state == pss_pkg::shutdown_state |->
			SRAM_PWR_EN == 14'h0000 ##1 !SRAM_GRANT;
	endproperty
	a_shutdown_sram: assert property (p_shutdown_sram)
		else $error("sram powered in shutdown");
	property p_main_off;
		@(posedge SYS_CLK) disable iff (!RST_N)
			is_sleep(state) |-> !MAIN_REG_EN &&
			VDOM_SRC[3:2] == pss_pkg::SRC_OFF;
	endproperty
	a_main_off: assert property (p_main_off)
		else $error("main regulator on in sleep");
	property p_src_legal;
		@(posedge SYS_CLK) disable iff (!RST_N)
			!is_sleep(state) |->
			VDOM_SRC[11:10] == pss_pkg::SRC_SCDC &&
			VDOM_SRC[3:2] == pss_pkg::SRC_MAIN;
	endproperty
	a_src_legal: assert property (p_src_legal)
		else $error("illegal source selection");
	property p_wfi_entry;
		@(posedge SYS_CLK) disable iff (!RST_N)
			is_active(state) ##1 state inside {
			pss_pkg::shutdown_state, pss_pkg::full_standby_state,
			pss_pkg::medium_standby_state,
			pss_pkg::reduced_standby_state} |-> $past(wfi_s2);
	endproperty
	a_wfi_entry: assert property (p_wfi_entry)
		else $error("standby entry without wfi");
	property p_periph_rst;
		@(posedge SYS_CLK) disable iff (!RST_N)
			is_sleep(state) ##1 is_active(state) |-> PERIPH_RST [*3];
	endproperty
	a_periph_rst: assert property (p_periph_rst)
		else $error("peripheral reset missing after sleep");
	property p_hold_wake;
		@(posedge SYS_CLK) disable iff (!RST_N)
			req_pending && state == next_state |=> $stable(wake_en);
	endproperty
	a_hold_wake: assert property (p_hold_wake)
		else $error("wake enables changed in flight");
	c_sleep: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
		is_sleep(state) ##[1:20] is_active(state));
	c_standby: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
		state == pss_pkg::reduced_standby_state);
	c_shutdown: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
		state == pss_pkg::shutdown_state);
endmodule
`default_nettype wire

// [design/pss_pkg.sv]
// constants, register map and state types of the power-state sequencer
package pss_pkg;

	// ****************************************************************
	// register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] STATE_OFF   = 8'h00;
	localparam logic [7:0] REQ_OFF     = 8'h04;
	localparam logic [7:0] WAKEEN_OFF  = 8'h08;
	localparam logic [7:0] SRAMPWR_OFF = 8'h0c;
	localparam logic [7:0] VSEL_OFF    = 8'h10;
	localparam logic [7:0] STORE_OFF   = 8'h14;
	localparam logic [7:0] INFO_OFF    = 8'h18;

	// ****************************************************************
	// sizes and reset values
	// ****************************************************************
	localparam int          N_SRAM       = 14;
	localparam int          N_WAKE       = 16;
	localparam int          N_VDOM       = 6;
	localparam int          N_STORE      = 3;
	localparam logic [13:0] SRAM_RST     = 14'h3fff;
	localparam logic [2:0]  STORE_RST    = 3'h7;
	localparam logic [15:0] WAKEEN_RST   = 16'h0000;
	localparam logic [3:0]  PERIPH_RST_CYC = 4'h8;
	// bank sizes in KB, banks 0..13, and storage set sizes in bytes
	localparam logic [13:0][7:0] SRAM_KB = {8'h02, 8'h02, 8'h02, 8'h02,
		8'h40, 8'h40, 8'h40, 8'h40, 8'h20, 8'h10,
		8'h04, 8'h04, 8'h04, 8'h04};
	localparam logic [2:0][7:0] STORE_BYTES = {8'h10, 8'h08, 8'h08};
	localparam logic [15:0] INFO_VALUE = 16'h0000;

	// ****************************************************************
	// request and supply codes
	// ****************************************************************
	localparam logic [1:0] REQ_STANDBY  = 2'h1;
	localparam logic [1:0] REQ_SLEEP    = 2'h2;
	localparam logic [1:0] REQ_SHUTDOWN = 2'h3;
	localparam logic [1:0] SRC_MAIN     = 2'h0; // 1.15 V or 1.05 V
	localparam logic [1:0] SRC_SCDC     = 2'h1; // 1.05 V
	localparam logic [1:0] SRC_LOW      = 2'h2; // 0.75 V
	localparam logic [1:0] SRC_OFF      = 2'h3;
	localparam logic [1:0] MAIN_115     = 2'h0;
	localparam logic [1:0] MAIN_105     = 2'h1;
	localparam logic [11:0] VSEL_RST    = 12'h400;

	typedef enum logic [3:0] {
		full_active_state, medium_active_state, reduced_active_state,
		cpu_gated_low_state, full_standby_state, medium_standby_state,
		reduced_standby_state, full_sleep_state, medium_sleep_state,
		reduced_sleep_state, shutdown_state
	} pstate_e;

endpackage

// [design/pss_wake_sync.sv]
// two-flop synchroniser for the wakeup event pins
`timescale 1ns/1ps
`default_nettype none
module pss_wake_sync (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] async_in,
	output logic      [15:0] sync_out
);
	logic [15:0] meta;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta     <= 16'h0000;
			sync_out <= 16'h0000;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule
`default_nettype wire

// [testbench/pss_cpu_model.sv]
// processor core and wakeup source model driving wfi and wake lines
`timescale 1ns/1ps
`default_nettype none
module pss_cpu_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [1:0]  cmd,
	input  wire logic [3:0]  src,
	input  wire logic        cpu_clk_en,
	output logic             wait_for_interrupt_instruction,
	output logic      [15:0] wake_irq
);
	// ****************************************************************
	// core behaviour
	// ****************************************************************
	logic clk_en_d;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wait_for_interrupt_instruction      <= 1'b0;
			wake_irq <= 16'h0000;
			clk_en_d <= 1'b1;
		end else begin
			clk_en_d <= cpu_clk_en;
			if (cpu_clk_en && !clk_en_d) begin
				// core resumed: leave wfi, sources serviced
				wait_for_interrupt_instruction      <= 1'b0;
				wake_irq <= 16'h0000;
			end else begin
				// wfi raised when cmd is 1 except in the cycle the core resumes, whether or not software wrote a request
				if (cmd == 2'h1) wait_for_interrupt_instruction <= 1'b1;
				// one wakeup interrupt source raised
				if (cmd == 2'h2) wake_irq[src] <= 1'b1;
				if (cmd == 2'h3) wake_irq <= 16'h0000;
			end
		end
	end
endmodule
`default_nettype wire

// [testbench/tb_power_state_sequencer.sv]
// self-checking testbench of the power-state sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_power_state_sequencer;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic        SYS_CLK, RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, SRAM_REQ;
	logic [7:0]  WB_ADR_I;
	logic [3:0]  WB_SEL_I, src;
	logic [31:0] WB_DAT_I, WB_DAT_O, q;
	logic        WB_ACK_O, WAIT_FOR_INTERRUPT_INSTRUCTION, SRAM_GRANT, MAIN_REG_EN;
	logic        CPU_CLK_EN, CPU_PWR_EN, PERIPH_RST, prst_d;
	logic [15:0] WAKE_IRQ;
	logic [13:0] SRAM_PWR_EN;
	logic [2:0]  STORE_PWR_EN;
	logic [11:0] VDOM_SRC;
	logic [1:0]  MAIN_LEVEL, cmd;
	int          errors, checks_done, pulses;

	power_state_sequencer DUT (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
		.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
		.WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
		.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WAIT_FOR_INTERRUPT_INSTRUCTION(WAIT_FOR_INTERRUPT_INSTRUCTION),
		.WAKE_IRQ(WAKE_IRQ), .SRAM_REQ(SRAM_REQ), .SRAM_GRANT(SRAM_GRANT),
		.SRAM_PWR_EN(SRAM_PWR_EN), .STORE_PWR_EN(STORE_PWR_EN),
		.VDOM_SRC(VDOM_SRC), .MAIN_LEVEL(MAIN_LEVEL),
		.MAIN_REG_EN(MAIN_REG_EN), .CPU_CLK_EN(CPU_CLK_EN),
		.CPU_PWR_EN(CPU_PWR_EN), .PERIPH_RST(PERIPH_RST));

	pss_cpu_model cpu (.clk(SYS_CLK), .rst_n(RST_N), .cmd(cmd), .src(src),
		.cpu_clk_en(CPU_CLK_EN), .wait_for_interrupt_instruction(WAIT_FOR_INTERRUPT_INSTRUCTION), .wake_irq(WAKE_IRQ));

	always #2 SYS_CLK = ~SYS_CLK;

	// counts rising edges of the peripheral reset after release
	always @(posedge SYS_CLK) begin
		prst_d <= PERIPH_RST;
		if (RST_N && PERIPH_RST === 1'b1 && prst_d === 1'b0) pulses++;
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic results;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask

	// classic single wishbone cycle, entered just after a rising edge
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I  <= we;
		WB_ADR_I <= a;
		WB_DAT_I <= d;
		WB_SEL_I <= 4'hf;
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (WB_ACK_O !== 1'b1 && n < 20);
		q = WB_DAT_O;
		if (n >= 20) begin
			errors++;
			results();
		end
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		WB_WE_I  <= 1'b0;
		@(posedge SYS_CLK);
	endtask

	task automatic do_cmd(input logic [1:0] c, input logic [3:0] s);
		cmd <= c;
		src <= s;
		@(posedge SYS_CLK);
		cmd <= 2'h0;
		@(posedge SYS_CLK);
	endtask

	// polls the state register until it shows the expected state
	task automatic wait_state(input logic [3:0] st);
		int n;
		n = 0;
		do begin
			wb(1'b0, pss_pkg::STATE_OFF, 32'h0);
			n++;
		end while (q[3:0] !== st && n < 60);
		check("state", {28'h0, q[3:0]}, {28'h0, st});
		if (q[3:0] !== st) results();
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		SYS_CLK = 1'b0;
		RST_N = 1'b0;
		{WB_CYC_I, WB_STB_I, WB_WE_I, SRAM_REQ} = 4'h0;
		WB_ADR_I = 8'h00;
		WB_SEL_I = 4'h0;
		WB_DAT_I = 32'h0;
		cmd = 2'h0;
		src = 4'h0;
		errors = 0;
		checks_done = 0;
		pulses = 0;
		repeat (10) @(posedge SYS_CLK);
		check("prst", 32'(PERIPH_RST), 32'h1);
		check("sram_en", 32'(SRAM_PWR_EN), 32'(pss_pkg::SRAM_RST));
		check("store_en", 32'(STORE_PWR_EN), 32'h7);
		check("vdom", 32'(VDOM_SRC), 32'(pss_pkg::VSEL_RST));
		RST_N <= 1'b1;
		SRAM_REQ <= 1'b1;
		@(posedge SYS_CLK);
		wb(1'b0, pss_pkg::STATE_OFF, 32'h0);
		check("state_rst", q & 32'h3ff, 32'h0);
		wb(1'b0, pss_pkg::WAKEEN_OFF, 32'h0);
		check("wakeen_rst", q, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		check("unmapped", q, 32'h0);
		wb(1'b0, pss_pkg::INFO_OFF, 32'h0);
		check("info", q, {pss_pkg::INFO_VALUE, 8'h10, 8'h02});
		check("grant", 32'(SRAM_GRANT), 32'h1);
		wb(1'b1, pss_pkg::SRAMPWR_OFF, 32'h1ffe);
		check("sram_off", 32'(SRAM_PWR_EN), 32'h1ffe);
		wb(1'b1, pss_pkg::SRAMPWR_OFF, 32'h3fff);
		wb(1'b1, pss_pkg::VSEL_OFF, 32'h404);
		check("vsel_bad", 32'(VDOM_SRC), 32'h400);
		wb(1'b1, pss_pkg::VSEL_OFF, 32'h1402);
		check("vsel_low", 32'(VDOM_SRC), 32'h402);
		check("main_lvl", 32'(MAIN_LEVEL), 32'h1);
		wb(1'b1, pss_pkg::STORE_OFF, 32'h5);
		check("store", 32'(STORE_PWR_EN), 32'h5);
		wb(1'b1, pss_pkg::STORE_OFF, 32'h7);
		// standby from medium active, wait for wfi, enabled wake only
		wb(1'b1, pss_pkg::WAKEEN_OFF, 32'h1);
		wb(1'b1, pss_pkg::REQ_OFF, 32'h1);
		wait_state(4'(pss_pkg::medium_active_state));
		wb(1'b1, pss_pkg::REQ_OFF, 32'h5);
		repeat (20) @(posedge SYS_CLK);
		wb(1'b0, pss_pkg::STATE_OFF, 32'h0);
		check("no_wfi", q & 32'h20f, 32'h201);
		wb(1'b1, pss_pkg::WAKEEN_OFF, 32'hffff);
		wb(1'b0, pss_pkg::WAKEEN_OFF, 32'h0);
		check("wakeen_held", q, 32'h1);
		do_cmd(2'h1, 4'h0);
		wait_state(4'(pss_pkg::medium_standby_state));
		check("cpu_clk", 32'(CPU_CLK_EN), 32'h0);
		do_cmd(2'h2, 4'h3);
		repeat (20) @(posedge SYS_CLK);
		wait_state(4'(pss_pkg::medium_standby_state));
		do_cmd(2'h3, 4'h0);
		do_cmd(2'h2, 4'h0);
		wait_state(4'(pss_pkg::medium_active_state));
		do_cmd(2'h3, 4'h0);
		// sleep from reduced active on software request alone
		wb(1'b1, pss_pkg::REQ_OFF, 32'h2);
		wait_state(4'(pss_pkg::reduced_active_state));
		pulses = 0;
		wb(1'b1, pss_pkg::REQ_OFF, 32'ha);
		wait_state(4'(pss_pkg::reduced_sleep_state));
		check("main_reg", 32'(MAIN_REG_EN), 32'h0);
		wb(1'b1, pss_pkg::SRAMPWR_OFF, 32'h0);
		check("sram_keep", 32'(SRAM_PWR_EN), 32'h3fff);
		do_cmd(2'h2, 4'h0);
		wait_state(4'(pss_pkg::reduced_active_state));
		repeat (20) @(posedge SYS_CLK);
		check("prst_pulse", 32'(pulses), 32'h1);
		do_cmd(2'h3, 4'h0);
		// shutdown refuses sram access, wakes to full active
		wb(1'b1, pss_pkg::REQ_OFF, 32'he);
		do_cmd(2'h1, 4'h0);
		wait_state(4'(pss_pkg::shutdown_state));
		repeat (4) @(posedge SYS_CLK);
		check("grant_off", 32'(SRAM_GRANT), 32'h0);
		do_cmd(2'h2, 4'h0);
		wait_state(4'(pss_pkg::full_active_state));
		do_cmd(2'h3, 4'h0);
		// reset in mid-run powers every sram bank again
		wb(1'b1, pss_pkg::SRAMPWR_OFF, 32'h1);
		check("sram_one", 32'(SRAM_PWR_EN), 32'h1);
		RST_N <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
		check("sram_rst", 32'(SRAM_PWR_EN), 32'h3fff);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		wb(1'b0, pss_pkg::STATE_OFF, 32'h0);
		check("state_rst2", q & 32'h3ff, 32'h0);
		results();
	end
endmodule
`default_nettype wire
